/* logic/sleep_ahb_slave.sv */
// AHB-Lite register slave, zero wait states
`timescale 1ns/1ns
`include "sleep_ctl_defs.svh"
module sleep_ahb_slave (
  input wire logic i_clk, // System clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_hsel, // Slave select
  input wire logic [31:0] i_haddr, // Byte address
  input wire logic [1:0] i_htrans, // Transfer type
  input wire logic i_hwrite, // Write when high
  input wire logic [2:0] i_hsize, // Transfer size
  input wire logic [31:0] i_hwdata, // Write data
  input wire logic i_hready, // Bus ready
  input wire logic [7:0] i_ctrl_rd, // Control register value
  input wire logic [7:0] i_stat_rd, // Status register value
  output logic o_wr_ctrl, // Control write strobe
  output logic [7:0] o_wr_data, // Control write data
  output logic [31:0] o_hrdata, // Read data
  output logic o_hreadyout, // Ready out
  output logic o_hresp // Response, always OKAY
);
  localparam sleep_ctl_pkg::ahb_state_t AHB_RST = '{default: '0, hreadyout: 1'b1};
  sleep_ctl_pkg::ahb_state_t st_ff;
  sleep_ctl_pkg::ahb_state_t nxt_st;
  logic acc;

  always_comb begin
    nxt_st = st_ff;
    acc = i_hsel & i_hready & i_htrans[1] & (i_hsize == `SC_HSIZE_WORD);
    nxt_st.hreadyout = 1'b1;
    nxt_st.hresp = 1'b0;
    nxt_st.dph_wr_ctrl = acc & i_hwrite & (i_haddr == `SC_CTRL_OFS);
    if (acc && !i_hwrite) begin
      if (i_haddr == `SC_CTRL_OFS) begin
        // A write still in its data phase has not reached the register yet
        nxt_st.hrdata = st_ff.dph_wr_ctrl ? 32'(i_hwdata[7:0] & `SC_CTRL_WMASK) : 32'(i_ctrl_rd);
      end else if (i_haddr == `SC_STAT_OFS) begin
        nxt_st.hrdata = 32'(i_stat_rd);
      end else begin
        nxt_st.hrdata = '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_ff <= AHB_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_wr_ctrl = st_ff.dph_wr_ctrl;
  assign o_wr_data = i_hwdata[7:0];
  assign o_hrdata = st_ff.hrdata;
  assign o_hreadyout = st_ff.hreadyout;
  assign o_hresp = st_ff.hresp;
endmodule : sleep_ahb_slave

/* logic/sleep_ctl_defs.svh */
// Named constants for the sleep mode controller
`ifndef SLEEP_CTL_DEFS_SVH
`define SLEEP_CTL_DEFS_SVH
`define SC_CTRL_OFS 32'h0000_0000
`define SC_STAT_OFS 32'h0000_0004
`define SC_CTRL_RST 8'h00
`define SC_CTRL_WMASK 8'h07
`define SC_SEN_BIT 0
`define SC_MODE_HI 2
`define SC_MODE_LO 1
`define SC_MODE_IDLE 2'h0
`define SC_MODE_STDBY 2'h1
`define SC_MODE_POWER_DOWN_CODE 2'h2
`define SC_MODE_RSVD 2'h3
`define SC_WAKE_CLKS 3'h6
`define SC_BOD_WAIT_CFG 2'h3
`define SC_HSIZE_WORD 3'h2
`define SC_ST_ACTIVE 2'h0
`define SC_ST_SLEEP 2'h1
`define SC_ST_WAKE_OSC 2'h3
`define SC_ST_WAKE_CNT 2'h2
`define SC_NSRC 11
`define SC_NPER 12
`define SC_NSTB 7
`define SC_STDBY_WAKE 11'h1ff
`define SC_POWER_DOWN_CODE_WAKE 11'h21b
`define SC_PER_RTC 0
`define SC_PER_CCL 1
`define SC_PER_PIT 7
`define SC_PER_WDT 8
`define SC_PER_BOD 9
`define SC_PER_EVENT_ROUTING 10
`define SC_PER_OTHER 11
`endif

/* logic/sleep_ctl_pkg.sv */
// Types shared by the sleep mode controller files
`include "sleep_ctl_defs.svh"
package sleep_ctl_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE = `SC_ST_ACTIVE,
    ST_SLEEP = `SC_ST_SLEEP,
    ST_WAKE_OSC = `SC_ST_WAKE_OSC,
    ST_WAKE_CNT = `SC_ST_WAKE_CNT
  } sleep_state_t;

  typedef struct packed {
    sleep_state_t state;
    logic sleep_enable_bit;
    logic [1:0] mode;
    logic [1:0] mode_lat;
    logic [2:0] cnt;
    logic halt;
    logic resume;
    logic [`SC_NSRC-1:0] wake_src;
    logic [`SC_NPER-1:0] periph;
    logic main_clk;
    logic rtc_clk;
    logic ulp_osc;
    logic wdt_osc;
    logic bod_osc;
    logic bod_samp;
    logic ccl_clk;
    logic dtt_clk;
  } ctl_state_t;

  typedef struct packed {
    logic dph_wr_ctrl;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_state_t;
endpackage : sleep_ctl_pkg

/* logic/sleep_mode_controller.sv */
// Sleep mode controller: mode entry, gating, wake-up timing
// Contract
// RULE1: Software enables wake interrupts before sleeping
// RULE2: No accepted wake source keeps device asleep
// RULE3: Sleep only on sleep instruction when enabled
// RULE4: Sleep enable is control bit zero
// RULE5: Mode codes Idle, Standby, Power-Down; fourth reserved
// RULE6: Control resets zero; upper bits read zero
// RULE7: Idle halts CPU only, all wake
// RULE8: Standby peripherals run per run-in-standby bit
// RULE9: Listed standby peripherals gated; others stop
// RULE10: Power-Down keeps brownout, watchdog, routing, periodic timer
// RULE11: Power-Down wakes on five listed sources
// RULE12: Standby wakes on listed sources only
// RULE13: Pin wake from Power-Down needs asynchronous sensing
// RULE14: Main clock per mode and standby requests
// RULE15: Watchdog, brownout oscillators always; dead-time only Idle
// RULE16: Wake takes six clocks plus oscillator start
// RULE17: Idle keeps main clock, no start-up
// RULE18: Power-Down low clocks only when used
// RULE19: Brownout fuse three extends wake until ready
// RULE20: Debug leaves controller normal except break
// RULE21: Debug break while asleep forces wake
// RULE22: Interrupt wake runs handler then resumes
// RULE23: Reset ends sleep; state kept while asleep
// RULE24: Sleep instruction without enable does nothing
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "sleep_ctl_defs.svh"
module sleep_mode_controller (
  input wire logic i_clk, // Peripheral clock, 100 MHz
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB ready in
  output logic [31:0] o_hrdata, // AHB read data
  output logic o_hreadyout, // AHB ready out
  output logic o_hresp, // AHB response
  input wire logic i_sleep_instr, // CPU executes sleep instruction
  input wire logic [`SC_NSRC-1:0] i_irq_req, // Enabled interrupt requests by source
  input wire logic i_debug_break, // Debug break request
  input wire logic [`SC_NSTB-1:0] i_run_stdby, // Run-in-standby bits of gated peripherals
  input wire logic i_main_clk_req, // Running peripheral requests main clock
  input wire logic i_main_osc_ready, // Main oscillator started
  input wire logic i_lowclk_req, // Brownout or watchdog uses low-power clock
  input wire logic i_bod_ready, // Brownout detector ready
  input wire logic [1:0] i_brownout_config_fuse, // Brownout active-mode fuse field
  output logic o_cpu_halt, // CPU instruction execution halted
  output logic o_resume, // One-cycle pulse, execution resumes
  output logic [`SC_NSRC-1:0] o_wake_src, // Sources that caused the last wake
  output logic [`SC_NPER-1:0] o_periph_run, // Peripheral run enables
  output logic o_main_clk_en, // Main clock source enable
  output logic o_rtc_clk_en, // Real-time counter clock enable
  output logic o_ulp_osc_en, // Ultra-low-power oscillator enable
  output logic o_wdt_osc_en, // Watchdog oscillator enable
  output logic o_bod_osc_en, // Brownout oscillator enable
  output logic o_bod_sampled, // Brownout in sampled operation
  output logic o_ccl_clk_en, // Custom logic clock enable
  output logic o_dtt_clk_en // Dead-time timer clock enable
);
  localparam sleep_ctl_pkg::ctl_state_t CTL_RST = '{
    state: sleep_ctl_pkg::ST_ACTIVE,
    sleep_enable_bit: 1'(`SC_CTRL_RST >> `SC_SEN_BIT),
    mode: `SC_MODE_IDLE,
    mode_lat: `SC_MODE_IDLE,
    cnt: '0,
    halt: 1'b0,
    resume: 1'b0,
    wake_src: '0,
    periph: '1,
    main_clk: 1'b1,
    rtc_clk: 1'b1,
    ulp_osc: 1'b1,
    wdt_osc: 1'b1,
    bod_osc: 1'b1,
    bod_samp: 1'b0,
    ccl_clk: 1'b1,
    dtt_clk: 1'b1
  };
  localparam logic [2:0] WAKE_LAST = `SC_WAKE_CLKS - 3'h1;

  sleep_ctl_pkg::ctl_state_t st_ff;
  sleep_ctl_pkg::ctl_state_t nxt_st;
  logic [`SC_NSRC-1:0] accept;
  logic wr_ctrl;
  logic [7:0] wr_data;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic [`SC_NSTB-1:0] stb_run;
  logic sleeping_n;
  logic idle_n;
  logic stdby_n;
  logic power_down_code_n;
  logic bod_ok;

  assign ctrl_rd = {5'h0, st_ff.mode, st_ff.sleep_enable_bit}; // RULE6
  assign stat_rd = {3'h0, st_ff.halt, st_ff.state, st_ff.mode_lat};

  sleep_ahb_slave u_bus (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .i_ctrl_rd(ctrl_rd),
    .i_stat_rd(stat_rd),
    .o_wr_ctrl(wr_ctrl),
    .o_wr_data(wr_data),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp)
  );

  // Acceptance follows the mode latched at sleep entry, not later writes
  sleep_wake_filter u_filter (
    .i_mode(st_ff.mode_lat),
    .i_irq_req(i_irq_req),
    .o_accept(accept)
  );

  // Brownout wait only applies with the fuse field at its wait code
  assign bod_ok = (i_brownout_config_fuse != `SC_BOD_WAIT_CFG) | i_bod_ready; // RULE19

  // Gating follows the next state so enables line up with the state flop
  assign sleeping_n = nxt_st.state != sleep_ctl_pkg::ST_ACTIVE;
  assign idle_n = !sleeping_n | (nxt_st.mode_lat == `SC_MODE_IDLE);
  assign stdby_n = sleeping_n & (nxt_st.mode_lat == `SC_MODE_STDBY);
  assign power_down_code_n = sleeping_n & (nxt_st.mode_lat == `SC_MODE_POWER_DOWN_CODE);

  genvar gi;
  generate
    for (gi = 0; gi < `SC_NSTB; gi++) begin : g_stb
      assign stb_run[gi] = idle_n | (stdby_n & i_run_stdby[gi]); // RULE8 RULE9
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.resume = 1'b0;
    if (wr_ctrl) begin
      nxt_st.sleep_enable_bit = wr_data[`SC_SEN_BIT]; // RULE4
      nxt_st.mode = wr_data[`SC_MODE_HI:`SC_MODE_LO]; // RULE5
    end
    case (st_ff.state)
      sleep_ctl_pkg::ST_ACTIVE: begin
        // Reserved mode code is refused like a clear enable bit
        if (i_sleep_instr && st_ff.sleep_enable_bit && (st_ff.mode != `SC_MODE_RSVD)) begin // RULE3 RULE5 RULE24
          nxt_st.state = sleep_ctl_pkg::ST_SLEEP;
          nxt_st.mode_lat = st_ff.mode;
        end
      end
      sleep_ctl_pkg::ST_SLEEP: begin
        // Without an accepted source or a break, stays here until reset
        if (i_debug_break || (|accept)) begin // RULE2 RULE20 RULE21
          nxt_st.wake_src = accept; // RULE22
          nxt_st.cnt = '0;
          if (st_ff.mode_lat == `SC_MODE_IDLE) begin
            nxt_st.state = sleep_ctl_pkg::ST_WAKE_CNT; // RULE17
          end else begin
            nxt_st.state = sleep_ctl_pkg::ST_WAKE_OSC; // RULE16
          end
        end
      end
      sleep_ctl_pkg::ST_WAKE_OSC: begin
        if (i_main_osc_ready) begin // RULE16
          nxt_st.state = sleep_ctl_pkg::ST_WAKE_CNT;
        end
      end
      sleep_ctl_pkg::ST_WAKE_CNT: begin
        if (st_ff.cnt != WAKE_LAST) begin
          nxt_st.cnt = st_ff.cnt + 3'h1; // RULE16
        end else if (bod_ok) begin // RULE19
          nxt_st.state = sleep_ctl_pkg::ST_ACTIVE;
          nxt_st.resume = 1'b1; // RULE22
        end
      end
      default: begin
        nxt_st.state = sleep_ctl_pkg::ST_ACTIVE;
      end
    endcase
    nxt_st.halt = sleeping_n; // RULE7
    nxt_st.periph[`SC_NSTB-1:0] = stb_run; // RULE9
    nxt_st.periph[`SC_PER_PIT] = 1'b1; // RULE10
    nxt_st.periph[`SC_PER_WDT] = 1'b1; // RULE10
    nxt_st.periph[`SC_PER_BOD] = 1'b1; // RULE10
    nxt_st.periph[`SC_PER_EVENT_ROUTING] = 1'b1; // RULE10
    nxt_st.periph[`SC_PER_OTHER] = idle_n; // RULE7 RULE9
    // Waking keeps the main oscillator on so its start-up can complete
    if (nxt_st.state == sleep_ctl_pkg::ST_WAKE_OSC || nxt_st.state == sleep_ctl_pkg::ST_WAKE_CNT) begin
      nxt_st.main_clk = 1'b1; // RULE16
    end else if (power_down_code_n) begin
      nxt_st.main_clk = 1'b0; // RULE14
    end else if (stdby_n) begin
      nxt_st.main_clk = i_main_clk_req; // RULE14
    end else begin
      nxt_st.main_clk = 1'b1; // RULE17
    end
    if (power_down_code_n) begin
      nxt_st.rtc_clk = i_lowclk_req; // RULE18
      nxt_st.ulp_osc = i_lowclk_req; // RULE18
    end else begin
      nxt_st.rtc_clk = idle_n | (stdby_n & i_run_stdby[`SC_PER_RTC]);
      nxt_st.ulp_osc = 1'b1;
    end
    nxt_st.ccl_clk = idle_n | (stdby_n & i_run_stdby[`SC_PER_CCL]);
    nxt_st.wdt_osc = 1'b1; // RULE15
    nxt_st.bod_osc = 1'b1; // RULE15
    nxt_st.bod_samp = sleeping_n; // RULE15
    nxt_st.dtt_clk = idle_n; // RULE15
  end

  // Contents survive sleep; only the system reset returns the defaults
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_ff <= CTL_RST; // RULE6 RULE23
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_cpu_halt = st_ff.halt;
  assign o_resume = st_ff.resume;
  assign o_wake_src = st_ff.wake_src;
  assign o_periph_run = st_ff.periph;
  assign o_main_clk_en = st_ff.main_clk;
  assign o_rtc_clk_en = st_ff.rtc_clk;
  assign o_ulp_osc_en = st_ff.ulp_osc;
  assign o_wdt_osc_en = st_ff.wdt_osc;
  assign o_bod_osc_en = st_ff.bod_osc;
  assign o_bod_sampled = st_ff.bod_samp;
  assign o_ccl_clk_en = st_ff.ccl_clk;
  assign o_dtt_clk_en = st_ff.dtt_clk;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_no_sleep_without_en;
    (st_ff.state == sleep_ctl_pkg::ST_ACTIVE) && i_sleep_instr && !st_ff.sleep_enable_bit
      |=> (st_ff.state == sleep_ctl_pkg::ST_ACTIVE) && !o_cpu_halt;
  endproperty
  a_no_sleep_without_en: assert property (p_no_sleep_without_en) else $error("sleep entered without enable"); // RULE24

  property p_sleep_entry;
    (st_ff.state == sleep_ctl_pkg::ST_ACTIVE) && i_sleep_instr && st_ff.sleep_enable_bit && (st_ff.mode != `SC_MODE_RSVD)
      |=> (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && o_cpu_halt && (st_ff.mode_lat == $past(st_ff.mode));
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered on enabled instruction"); // RULE3

  property p_stay_asleep;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && !(|accept) && !i_debug_break
      |=> (st_ff.state == sleep_ctl_pkg::ST_SLEEP);
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("woke without accepted source"); // RULE2

  property p_dbg_wake;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && i_debug_break |=> (st_ff.state != sleep_ctl_pkg::ST_SLEEP);
  endproperty
  a_dbg_wake: assert property (p_dbg_wake) else $error("debug break did not wake"); // RULE21

  sequence s_idle_wake;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && (st_ff.mode_lat == `SC_MODE_IDLE)
      && ((|accept) || i_debug_break) && (i_brownout_config_fuse != `SC_BOD_WAIT_CFG);
  endsequence
  sequence s_idle_resume;
    !o_resume [*6] ##1 (o_resume && !o_cpu_halt);
  endsequence
  property p_idle_wake_time;
    s_idle_wake |=> s_idle_resume;
  endproperty
  a_idle_wake_time: assert property (p_idle_wake_time) else $error("idle wake not six clocks"); // RULE16

  property p_power_down_code_main_off;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && (st_ff.mode_lat == `SC_MODE_POWER_DOWN_CODE)
      |-> !o_main_clk_en && !o_dtt_clk_en && o_wdt_osc_en && o_bod_osc_en;
  endproperty
  a_power_down_code_main_off: assert property (p_power_down_code_main_off) else $error("clock gating wrong in power-down"); // RULE14

  property p_power_down_code_accept;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && (st_ff.mode_lat == `SC_MODE_POWER_DOWN_CODE) && !i_debug_break
      && ((i_irq_req & `SC_POWER_DOWN_CODE_WAKE) == '0) |=> (st_ff.state == sleep_ctl_pkg::ST_SLEEP);
  endproperty
  a_power_down_code_accept: assert property (p_power_down_code_accept) else $error("power-down woke on wrong source"); // RULE11

  property p_bod_wait;
    (st_ff.state == sleep_ctl_pkg::ST_WAKE_CNT) && (i_brownout_config_fuse == `SC_BOD_WAIT_CFG) && !i_bod_ready
      |=> !o_resume && o_cpu_halt;
  endproperty
  a_bod_wait: assert property (p_bod_wait) else $error("resumed before brownout ready"); // RULE19

  property p_idle_periph;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && (st_ff.mode_lat == `SC_MODE_IDLE) |-> (&o_periph_run) && o_main_clk_en;
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle gated a peripheral"); // RULE7

  property p_osc_wait;
    (st_ff.state == sleep_ctl_pkg::ST_WAKE_OSC) && !i_main_osc_ready
      |=> (st_ff.state == sleep_ctl_pkg::ST_WAKE_OSC) && o_main_clk_en;
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("wake left before oscillator ready"); // RULE16

  property p_stdby_gate;
    (st_ff.state == sleep_ctl_pkg::ST_SLEEP) && (st_ff.mode_lat == `SC_MODE_STDBY) && $stable(i_run_stdby)
      && $past(st_ff.state == sleep_ctl_pkg::ST_SLEEP)
      |-> (o_periph_run[`SC_NSTB-1:0] == $past(i_run_stdby)) && !o_periph_run[`SC_PER_OTHER];
  endproperty
  a_stdby_gate: assert property (p_stdby_gate) else $error("standby gating wrong"); // RULE9
endmodule : sleep_mode_controller

/* logic/sleep_wake_filter.sv */
// Per-source wake-up acceptance by sleep mode
`timescale 1ns/1ns
`include "sleep_ctl_defs.svh"
module sleep_wake_filter (
  input wire logic [1:0] i_mode, // Latched sleep mode
  input wire logic [`SC_NSRC-1:0] i_irq_req, // Raw interrupt requests
  output logic [`SC_NSRC-1:0] o_accept // Requests allowed to wake
);
  localparam logic [`SC_NSRC-1:0] STDBY_MASK = `SC_STDBY_WAKE;
  localparam logic [`SC_NSRC-1:0] POWER_DOWN_CODE_MASK = `SC_POWER_DOWN_CODE_WAKE;

  genvar gi;
  generate
    for (gi = 0; gi < `SC_NSRC; gi++) begin : g_src
      assign o_accept[gi] = i_irq_req[gi] & ((i_mode == `SC_MODE_IDLE) | // RULE7
        ((i_mode == `SC_MODE_STDBY) & STDBY_MASK[gi]) | // RULE12
        ((i_mode == `SC_MODE_POWER_DOWN_CODE) & POWER_DOWN_CODE_MASK[gi])); // RULE11
    end
  endgenerate
endmodule : sleep_wake_filter

/* verif/cpu_irq_model.sv */
// Behavioural model of the CPU core and the interrupt request sources
`timescale 1ns/1ns
module cpu_irq_model (
  input wire logic i_clk, // Peripheral clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_exec_sleep, // Bench asks the core to run the sleep instruction
  input wire logic [10:0] i_raise, // Bench raises interrupt flags
  input wire logic i_halt, // Core halted by the controller
  input wire logic i_resume, // Execution resumes
  output logic o_sleep_instr, // Sleep instruction executed
  output logic [10:0] o_irq_req // Pending enabled requests
);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sleep_instr <= 1'b0;
      o_irq_req <= 11'h000;
    end else begin
      // A halted core executes nothing, so no sleep instruction while asleep
      o_sleep_instr <= i_exec_sleep & ~i_halt;
      if (i_resume) begin
        // The handler runs on resume and clears every pending request, not only the one that woke the core
        o_irq_req <= i_raise;
      end else begin
        // Pin sources are taken as asynchronously sensed and enabled ahead of sleep
        o_irq_req <= o_irq_req | i_raise;
      end
    end
  end
endmodule : cpu_irq_model

/* verif/testbench.sv */
// Self-checking bench for the sleep mode controller
`timescale 1ns/1ns
module testbench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic exec = 1'b0;
  logic [10:0] raise = 11'h0;
  logic brk = 1'b0;
  logic [6:0] rs = 7'h0;
  logic mreq = 1'b0;
  logic lreq = 1'b0;
  logic osc_rdy = 1'b1;
  logic bod_rdy = 1'b1;
  logic [1:0] fuse = 2'h0;
  logic sleep_instr, hrdyo, hresp, halt, resume;
  logic mclk_en, rtc_en, ulp_en, wdt_en, bodo_en, bsamp, ccl_en, dtt_en;
  logic [10:0] irq, wsrc;
  logic [11:0] prun;
  logic [31:0] hrdata, d;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 35302;
  int n;
  int sb_ok[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8};
  int pd_ok[$] = '{0, 1, 3, 4, 9};

  always #5 i_clk = ~i_clk;

  sleep_mode_controller dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdyo),
    .o_hrdata(hrdata), .o_hreadyout(hrdyo), .o_hresp(hresp), .i_sleep_instr(sleep_instr),
    .i_irq_req(irq), .i_debug_break(brk), .i_run_stdby(rs), .i_main_clk_req(mreq),
    .i_main_osc_ready(osc_rdy), .i_lowclk_req(lreq), .i_bod_ready(bod_rdy),
    .i_brownout_config_fuse(fuse), .o_cpu_halt(halt), .o_resume(resume), .o_wake_src(wsrc),
    .o_periph_run(prun), .o_main_clk_en(mclk_en), .o_rtc_clk_en(rtc_en), .o_ulp_osc_en(ulp_en),
    .o_wdt_osc_en(wdt_en), .o_bod_osc_en(bodo_en), .o_bod_sampled(bsamp), .o_ccl_clk_en(ccl_en),
    .o_dtt_clk_en(dtt_en));

  cpu_irq_model cpu (.i_clk(i_clk), .i_nrst(i_nrst), .i_exec_sleep(exec), .i_raise(raise),
    .i_halt(halt), .i_resume(resume), .o_sleep_instr(sleep_instr), .o_irq_req(irq));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Single word transfer; the request holds until hready is seen high
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge i_clk); while (hrdyo !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge i_clk); while (hrdyo !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic sleep_go(input logic brownout_detector);
    @(posedge i_clk);
    d = $random(seed);
    rs <= d[6:0];
    mreq <= d[7];
    lreq <= d[8];
    osc_rdy <= 1'b0;
    bod_rdy <= brownout_detector;
    exec <= 1'b1;
    @(posedge i_clk);
    exec <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : sleep_go

  // Count edges from the one that takes the wake cause to the resume pulse
  task automatic wake(input logic [10:0] msk, input logic b, input int od, input int bd, output int cnt);
    @(posedge i_clk);
    raise <= msk;
    @(posedge i_clk);
    raise <= 11'h000;
    brk <= b;
    cnt = 0;
    while (cnt < 200) begin
      @(posedge i_clk);
      cnt++;
      brk <= 1'b0;
      if (cnt == od) osc_rdy <= 1'b1;
      if (cnt == bd) bod_rdy <= 1'b1;
      #1;
      if (resume === 1'b1) break;
    end
  endtask : wake

  function automatic bit allowed(input int m, input int s);
    if (m == 0) return 1'b1;
    if (m == 1) return s inside {sb_ok};
    return s inside {pd_ok};
  endfunction : allowed

  task automatic chk_gate(input int m);
    logic [11:0] ep;
    ep = (m == 0) ? 12'hfff : {1'b0, 4'hf, (m == 1) ? rs : 7'h00};
    check("periph_run", prun, ep);
    check("main_clk", mclk_en, (m == 0) | ((m == 1) & mreq));
    check("rtc_clk", rtc_en, (m == 0) | ((m == 1) ? rs[0] : lreq));
    if (m == 2) check("ulp_osc", ulp_en, lreq);
    check("ccl_clk", ccl_en, (m == 0) | ((m == 1) & rs[1]));
    check("always_osc", {wdt_en, bodo_en, bsamp}, 3'h7);
    check("dtt_clk", dtt_en, m == 0);
  endtask : chk_gate

  initial begin
    #(10 * 30000);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check("rst_outs", {halt, resume, bsamp, wsrc}, 14'h0);
    check("rst_gate", {prun, mclk_en, rtc_en, ulp_en, wdt_en, bodo_en, ccl_en, dtt_en}, 19'h7ffff);
    ahb(1'b0, 32'h0, 32'h0, d);
    check("ctrl_rst", d, 32'h0);
    for (int i = 0; i < 5; i++) begin
      n = (i == 0) ? 32'hffff_ffff : $random(seed);
      ahb(1'b1, 32'h0, n, d);
      ahb(1'b0, 32'h0, 32'h0, d);
      check("ctrl_rw", d, n & 7);
    end
    ahb(1'b1, 32'h8, 32'h0, d);
    ahb(1'b0, 32'h8, 32'h0, d);
    check("unmapped", d, 32'h0);
    ahb(1'b0, 32'h0, 32'h0, d);
    check("ctrl_kept", d, n & 7);
    ahb(1'b1, 32'h0, 32'h4, d);
    sleep_go(1'b1);
    check("no_enable", halt, 1'b0);
    ahb(1'b1, 32'h0, 32'h7, d);
    sleep_go(1'b1);
    check("reserved_mode", halt, 1'b0);
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, 32'h0, 32'(m * 2 + 1), d);
      for (int s = 0; s < 11; s++) begin
        sleep_go(1'b1);
        check("halt_entry", halt, 1'b1);
        chk_gate(m);
        // A refused source is paired with a debug break so the core still returns
        wake(11'h001 << s, !allowed(m, s), 5, 0, n);
        check("wake_cycles", n, (m == 0) ? 7 : 12);
        check("wake_src", wsrc, allowed(m, s) ? (32'h1 << s) : 32'h0);
        check("halt_resume", halt, 1'b0);
      end
    end
    ahb(1'b1, 32'h0, 32'h1, d);
    fuse <= 2'h3;
    sleep_go(1'b1);
    wake(11'h001, 1'b0, 5, 0, n);
    check("bod_early", n, 7);
    sleep_go(1'b0);
    wake(11'h001, 1'b0, 5, 10, n);
    check("bod_late", n, 11);
    fuse <= 2'h0;
    ahb(1'b1, 32'h0, 32'h5, d);
    sleep_go(1'b1);
    repeat (40) @(posedge i_clk);
    #1;
    check("no_source", halt, 1'b1);
    ahb(1'b0, 32'h0, 32'h0, d);
    check("ctrl_asleep", d, 32'h5);
    // Status: halt at bit 4, state sleep in 3:2, latched power-down mode in 1:0
    ahb(1'b0, 32'h4, 32'h0, d);
    check("status_asleep", d, 32'h16);
    check("hresp", hresp, 1'b0);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check("reset_wakes", halt, 1'b0);
    ahb(1'b0, 32'h0, 32'h0, d);
    check("ctrl_after_rst", d, 32'h0);
    final_report();
  end
endmodule : testbench
